// ---- inc/exc_pkg.sv ----
// constants, types and state layout of the top-level exception controller
// Operation
// - after reset, fetch the stack pointer from vector entry zero, then the reset vector
// - reset exception at position 1 on power-up and warm reset, then thread mode
// - nonmaskable exception at position 2, preempted by nothing but reset
// - a fault that cannot activate escalates to hard fault at position 3
// - memory protection mismatch raises memory fault at position 4
// - address and memory faults raise bus fault at position 5, precise or imprecise
// - undefined instruction or illegal state raises usage fault at position 6
// - supervisor call instruction raises service call at position 11
// - debug monitor at 12 only when enabled, not halting, higher than current
// - pendable service request at 14 is pended by software only
// - system tick expiry raises the exception at position 15
// - peripheral lines sit at positions 18 to 32, others reserved
// - reset, nonmaskable, hard fault hold the three top fixed priorities
// - all other exceptions take a 5-bit priority, lower value is higher
// - equal priorities are broken by lower table position
// - zero bits written to set, clear or active registers change nothing
// - enable-set one unmasks a line, enable-clear one masks it
// - each line has a pending latch set and cleared by write-one, independent of the mask
// - active register is read-only and shows lines in service
// - a pending line is taken only while enabled, even if enabled later
// - line requests are level-sensitive, not edge-detected
// - a line driven by the event merger stays pending while its level holds
package exc_pkg;

	localparam int EXC_NUM = 33;
	localparam int IDX_W = 6;
	localparam int PRIO_W = 5;
	localparam int KEY_W = 7;
	localparam int LINE_W = 17;
	localparam int LINE_BASE = 16;
	localparam int FAULT_NUM = 3;

	// table positions
	localparam int POS_STACK = 0;
	localparam int POS_RESET = 1;
	localparam int POS_NMI = 2;
	localparam int POS_HARD = 3;
	localparam int POS_MEM = 4;
	localparam int POS_BUS = 5;
	localparam int POS_USAGE = 6;
	localparam int POS_SVC = 11;
	localparam int POS_DBGMON = 12;
	localparam int POS_PENDABLE_SERVICE_REQUEST = 14;
	localparam int POS_TICK = 15;
	localparam int POS_MGMT = 18;
	localparam int POS_BASEBAND = 19;
	localparam int POS_SLEEPTMR = 20;
	localparam int POS_SERIAL = 21;
	localparam int POS_SECURITY = 23;
	localparam int POS_MACTMR = 24;
	localparam int POS_MACTX = 25;
	localparam int POS_MACRX = 26;
	localparam int POS_EXT_A = 28;
	localparam int POS_EXT_C = 30;
	localparam int POS_EXT_D = 31;
	localparam int POS_DEBUG = 32;

	// line bit n is position LINE_BASE+n; reserved bits stay zero
	localparam logic [LINE_W-1:0] LINE_IMPL = 17'h1D7BC;

	localparam int FAULT_POS [FAULT_NUM] = '{POS_MEM, POS_BUS, POS_USAGE};

	typedef logic [KEY_W-1:0] key_t;

	localparam logic [1:0] GRP_CFG = 2'h1;
	localparam key_t KEY_RESET = 7'h00;
	localparam key_t KEY_NMI = 7'h01;
	localparam key_t KEY_HARD = 7'h02;
	localparam key_t KEY_IDLE = 7'h7F;

	localparam logic [31:0] VEC_SP_ADDR = 32'h00000000;
	localparam logic [31:0] VEC_RESET_ADDR = 32'h00000004;

	typedef enum logic [2:0] {
		BOOT_SP = 3'h1,
		BOOT_PC = 3'h2,
		BOOT_RUN = 3'h4
	} boot_t;

	typedef struct packed {
		boot_t boot;
		logic vec_rd_req;
		logic [31:0] vec_rd_addr;
		logic [31:0] stack_ptr;
		logic [31:0] reset_pc;
		logic boot_done;
		logic thread_mode;
		logic [1:0] nmi_sync;
		logic nmi_prev;
		logic [1:0] warm_sync;
		logic [EXC_NUM-1:0] pend;
		logic [EXC_NUM-1:0] active;
		logic [LINE_W-1:0] line_en;
		logic exc_req;
		logic [IDX_W-1:0] exc_num;
		key_t run_key;
	} ctl_state_t;

	localparam logic [EXC_NUM-1:0] ACTIVE_RESET = 33'h000000002;

	localparam ctl_state_t STATE_RESET = '{
		boot: BOOT_SP,
		vec_rd_req: 1'h1,
		vec_rd_addr: VEC_SP_ADDR,
		stack_ptr: 32'h00000000,
		reset_pc: 32'h00000000,
		boot_done: 1'h0,
		thread_mode: 1'h0,
		nmi_sync: 2'h0,
		nmi_prev: 1'h0,
		warm_sync: 2'h0,
		pend: 33'h000000000,
		active: ACTIVE_RESET,
		line_en: 17'h00000,
		exc_req: 1'h0,
		exc_num: 6'h00,
		run_key: KEY_RESET
	};

endpackage : exc_pkg

// ---- hdl/exc_arbiter.sv ----
// picks the best-keyed candidate, lowest position on ties
`timescale 1ns/1ps
`default_nettype none
module exc_arbiter #(
	parameter int N = 33
) (
	// candidates
	input wire logic [N-1:0] cand,
	input wire logic [N-1:0][exc_pkg::KEY_W-1:0] keys,
	// winner
	output logic found,
	output logic [exc_pkg::IDX_W-1:0] idx,
	output exc_pkg::key_t key
);
	import exc_pkg::*;

	// strict compare while scanning upward keeps the lower position on a tie
	always_comb
	begin
		found = 1'b0;
		idx = '0;
		key = KEY_IDLE;
		for (int i = 0; i < N; i++)
		begin
			if (cand[i] && (!found || keys[i] < key))
			begin
				found = 1'b1;
				idx = IDX_W'(i);
				key = keys[i];
			end
		end
	end

endmodule : exc_arbiter
`default_nettype wire

// ---- hdl/exception_controller.sv ----
// top-level exception controller: pending, masking, ranking and activation
`timescale 1ns/1ps
`default_nettype none
module exception_controller (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// asynchronous pins
	input wire logic nmi_pin,
	input wire logic warm_reset_pin,
	// vector table fetch at boot
	output logic vec_rd_req,
	output logic [31:0] vec_rd_addr,
	input wire logic vec_rd_ack,
	input wire logic [31:0] vec_rd_data,
	output logic [31:0] stack_ptr,
	output logic [31:0] reset_pc,
	output logic boot_done,
	output logic thread_mode,
	input wire logic first_instr_done,
	// core exception events
	input wire logic mem_fault,
	input wire logic bus_fault_precise,
	input wire logic bus_fault_imprecise,
	input wire logic usage_fault,
	input wire logic svc_exec,
	input wire logic dbg_mon_req,
	input wire logic dbg_halting,
	input wire logic system_tick_exception_expire,
	// system configuration
	input wire logic [exc_pkg::FAULT_NUM-1:0] fault_handler_en,
	input wire logic dbg_mon_en,
	input wire logic pendable_service_request_set,
	input wire logic pendable_service_request_clear,
	input wire logic [exc_pkg::EXC_NUM-1:0][exc_pkg::PRIO_W-1:0] exc_priority,
	// peripheral lines and their write-one controls
	input wire logic [exc_pkg::LINE_W-1:0] line_irq,
	input wire logic [exc_pkg::LINE_W-1:0] line_enable_set,
	input wire logic [exc_pkg::LINE_W-1:0] line_enable_clear,
	input wire logic [exc_pkg::LINE_W-1:0] line_pend_set,
	input wire logic [exc_pkg::LINE_W-1:0] line_pend_clear,
	output logic [exc_pkg::LINE_W-1:0] line_enable,
	output logic [exc_pkg::LINE_W-1:0] line_pend,
	output logic [exc_pkg::LINE_W-1:0] line_active,
	// core handshake
	output logic exc_req,
	output logic [exc_pkg::IDX_W-1:0] exc_num,
	output exc_pkg::key_t running_key,
	input wire logic exc_accept,
	input wire logic exc_return,
	input wire logic [exc_pkg::IDX_W-1:0] exc_return_num
);
	import exc_pkg::*;

	ctl_state_t s_r;
	ctl_state_t s_nxt;
	logic [EXC_NUM-1:0][KEY_W-1:0] keys;
	logic [EXC_NUM-1:0] take_mask;
	logic [EXC_NUM-1:0] cand;
	logic best_found;
	logic [IDX_W-1:0] best_idx;
	key_t best_key;
	logic act_found;
	logic [IDX_W-1:0] act_idx;
	key_t act_key;
	key_t run_key;
	logic [FAULT_NUM-1:0] fault_evt;
	logic accepting;
	logic [EXC_NUM-1:0] keep_cand;

	// fixed keys sit in a group below every programmable one
	function automatic key_t exc_key(input int pos, input logic [PRIO_W-1:0] p);
		key_t k;
		k = {GRP_CFG, p};
		case (pos)
			POS_RESET: k = KEY_RESET;
			POS_NMI: k = KEY_NMI;
			POS_HARD: k = KEY_HARD;
			default: k = {GRP_CFG, p};
		endcase
		return k;
	endfunction : exc_key

	for (genvar g = 0; g < EXC_NUM; g++)
	begin : g_key
		assign keys[g] = exc_key(g, exc_priority[g]);
	end

	// system positions are always takeable; lines only through their mask
	assign take_mask = {s_r.line_en, 16'hFFFF};
	assign cand = s_r.pend & take_mask;

	exc_arbiter #(
		.N(EXC_NUM)
	) u_pend_arb (
		.cand(cand),
		.keys(keys),
		.found(best_found),
		.idx(best_idx),
		.key(best_key)
	);

	// the same ranking over the active set gives the running priority
	exc_arbiter #(
		.N(EXC_NUM)
	) u_act_arb (
		.cand(s_r.active),
		.keys(keys),
		.found(act_found),
		.idx(act_idx),
		.key(act_key)
	);

	assign run_key = act_found ? act_key : KEY_IDLE;
	assign fault_evt = {usage_fault, bus_fault_precise, mem_fault};
	assign accepting = exc_accept && s_r.exc_req;

	always_comb
	begin
		s_nxt = s_r;
		keep_cand = '0;

		// two-stage synchronisers for the pins
		s_nxt.nmi_sync = {s_r.nmi_sync[0], nmi_pin};
		s_nxt.warm_sync = {s_r.warm_sync[0], warm_reset_pin};
		s_nxt.nmi_prev = s_r.nmi_sync[1];

		// boot: stack pointer first, reset vector second
		case (s_r.boot)
			BOOT_SP:
			begin
				s_nxt.vec_rd_req = 1'b1;
				s_nxt.vec_rd_addr = VEC_SP_ADDR;
				if (vec_rd_ack && s_r.vec_rd_req)
				begin
					s_nxt.stack_ptr = vec_rd_data;
					s_nxt.vec_rd_addr = VEC_RESET_ADDR;
					s_nxt.boot = BOOT_PC;
				end
			end
			BOOT_PC:
			begin
				if (vec_rd_ack && s_r.vec_rd_req)
				begin
					s_nxt.reset_pc = vec_rd_data;
					s_nxt.vec_rd_req = 1'b0;
					s_nxt.boot_done = 1'b1;
					s_nxt.boot = BOOT_RUN;
				end
			end
			BOOT_RUN:
			begin
				// reset handler hands over to thread level after one instruction
				if (first_instr_done && s_r.active[POS_RESET])
				begin
					s_nxt.active[POS_RESET] = 1'b0;
				end
			end
			default:
			begin
				s_nxt.boot = BOOT_SP;
			end
		endcase

		// clears come first so every hardware set below wins over them
		if (exc_return && exc_return_num < IDX_W'(EXC_NUM) && exc_return_num != IDX_W'(POS_RESET))
		begin
			s_nxt.active[exc_return_num] = 1'b0;
		end
		if (accepting)
		begin
			s_nxt.pend[s_r.exc_num] = 1'b0;
			s_nxt.active[s_r.exc_num] = 1'b1;
		end
		if (pendable_service_request_clear)
		begin
			s_nxt.pend[POS_PENDABLE_SERVICE_REQUEST] = 1'b0;
		end
		// only the one-bits of a write act; zero bits keep the state
		s_nxt.pend[EXC_NUM-1:LINE_BASE] = s_nxt.pend[EXC_NUM-1:LINE_BASE] & ~line_pend_clear;
		s_nxt.line_en = (s_r.line_en & ~line_enable_clear) | (line_enable_set & LINE_IMPL);

		// line latches follow the request level every cycle it is high
		s_nxt.pend[EXC_NUM-1:LINE_BASE] = s_nxt.pend[EXC_NUM-1:LINE_BASE]
			| ((line_pend_set | line_irq) & LINE_IMPL);

		if (s_r.boot_done)
		begin
			// synchronous faults must beat the running level or escalate
			for (int f = 0; f < FAULT_NUM; f++)
			begin
				if (fault_evt[f])
				begin
					if (fault_handler_en[f] && keys[FAULT_POS[f]] < run_key)
					begin
						s_nxt.pend[FAULT_POS[f]] = 1'b1;
					end
					else
					begin
						s_nxt.pend[POS_HARD] = 1'b1;
					end
				end
			end
			// imprecise bus faults arrive late and only escalate when disabled
			if (bus_fault_imprecise)
			begin
				if (fault_handler_en[1])
				begin
					s_nxt.pend[POS_BUS] = 1'b1;
				end
				else
				begin
					s_nxt.pend[POS_HARD] = 1'b1;
				end
			end
			if (svc_exec)
			begin
				if (keys[POS_SVC] < run_key)
				begin
					s_nxt.pend[POS_SVC] = 1'b1;
				end
				else
				begin
					s_nxt.pend[POS_HARD] = 1'b1;
				end
			end
			if (dbg_mon_req && dbg_mon_en && !dbg_halting)
			begin
				s_nxt.pend[POS_DBGMON] = 1'b1;
			end
			if (pendable_service_request_set)
			begin
				s_nxt.pend[POS_PENDABLE_SERVICE_REQUEST] = 1'b1;
			end
			if (system_tick_exception_expire)
			begin
				s_nxt.pend[POS_TICK] = 1'b1;
			end
			// a new rising level on the pin pends the nonmaskable exception
			if (s_r.nmi_sync[1] && !s_r.nmi_prev)
			begin
				s_nxt.pend[POS_NMI] = 1'b1;
			end
		end

		// equal keys never preempt; only a strictly better one does
		// the ranking sees last cycle's state, so a request cleared or masked at this edge must not go out
		keep_cand = s_nxt.pend & {s_nxt.line_en, 16'hFFFF};
		s_nxt.exc_req = s_r.boot_done && best_found && (best_key < run_key) && !accepting
			&& keep_cand[best_idx];
		s_nxt.exc_num = best_idx;
		s_nxt.run_key = run_key;
		s_nxt.thread_mode = s_nxt.boot_done && (s_nxt.active == '0);

		// warm reset restarts everything but the synchronisers
		if (s_r.warm_sync[1])
		begin
			s_nxt = STATE_RESET;
			s_nxt.nmi_sync = {s_r.nmi_sync[0], nmi_pin};
			s_nxt.warm_sync = {s_r.warm_sync[0], warm_reset_pin};
			s_nxt.nmi_prev = s_r.nmi_sync[1];
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s_r <= STATE_RESET;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign vec_rd_req = s_r.vec_rd_req;
	assign vec_rd_addr = s_r.vec_rd_addr;
	assign stack_ptr = s_r.stack_ptr;
	assign reset_pc = s_r.reset_pc;
	assign boot_done = s_r.boot_done;
	assign thread_mode = s_r.thread_mode;
	assign line_enable = s_r.line_en;
	assign line_pend = s_r.pend[EXC_NUM-1:LINE_BASE];
	// read-only view; no port writes it
	assign line_active = s_r.active[EXC_NUM-1:LINE_BASE];
	assign exc_req = s_r.exc_req;
	assign exc_num = s_r.exc_num;
	assign running_key = s_r.run_key;

endmodule : exception_controller
`default_nettype wire

// ---- tb/exception_controller_sva.sv ----
// port assertions for the exception controller
`timescale 1ns/1ps
`default_nettype none
module exception_controller_sva
	import exc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic warm_reset_pin,
	// boot fetch
	input wire logic vec_rd_req,
	input wire logic [31:0] vec_rd_addr,
	input wire logic vec_rd_ack,
	input wire logic [31:0] vec_rd_data,
	input wire logic [31:0] stack_ptr,
	input wire logic [31:0] reset_pc,
	input wire logic boot_done,
	// lines
	input wire logic [LINE_W-1:0] line_irq,
	input wire logic [LINE_W-1:0] line_enable_set,
	input wire logic [LINE_W-1:0] line_enable_clear,
	input wire logic [LINE_W-1:0] line_pend_set,
	input wire logic [LINE_W-1:0] line_pend_clear,
	input wire logic [LINE_W-1:0] line_enable,
	input wire logic [LINE_W-1:0] line_pend,
	input wire logic [LINE_W-1:0] line_active,
	// core handshake
	input wire logic exc_req,
	input wire logic [IDX_W-1:0] exc_num,
	input wire key_t running_key,
	input wire logic exc_accept
);
	logic [3:0] warm_hist;
	// the pin acts through two flip-flops, so checks stay off until the forced state has drained
	always_ff @(posedge clk)
	begin
		if (rst)
			warm_hist <= 4'h0;
		else
			warm_hist <= {warm_hist[2:0], warm_reset_pin};
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst || warm_reset_pin || warm_hist != 4'h0);
	sequence s_sp_taken;
		vec_rd_req && vec_rd_ack && vec_rd_addr == VEC_SP_ADDR;
	endsequence
	sequence s_pc_taken;
		vec_rd_req && vec_rd_ack && vec_rd_addr == VEC_RESET_ADDR;
	endsequence
	AST_BOOT_SP: assert property (s_sp_taken |=> vec_rd_addr == VEC_RESET_ADDR && stack_ptr == $past(vec_rd_data))
		else $error("stack pointer fetch wrong");
	AST_BOOT_PC: assert property (s_pc_taken |=> !vec_rd_req && boot_done && reset_pc == $past(vec_rd_data))
		else $error("reset vector fetch wrong");
	AST_NO_REQ_RESET: assert property (running_key == KEY_RESET |-> !exc_req)
		else $error("request under reset priority");
	AST_ACCEPT: assert property (exc_req && exc_accept |=> !exc_req)
		else $error("request stays after accept");
	AST_ACCEPT_ACTIVE: assert property (exc_req && exc_accept && exc_num >= 6'h12 |=> line_active[$past(exc_num) - 6'h10])
		else $error("accepted line not active");
	AST_MASK: assert property (exc_req && exc_num >= 6'h12 |-> line_enable[exc_num - 6'h10])
		else $error("masked line requested");
	AST_EN: assert property (1'b1 |=> (line_enable & $past(line_enable_set & LINE_IMPL)) == $past(line_enable_set & LINE_IMPL)
		&& (line_enable & $past(line_enable_clear & ~line_enable_set)) == '0)
		else $error("enable set or clear lost");
	AST_PEND: assert property (!exc_accept |=> ($past((line_irq | line_pend_set) & LINE_IMPL) & ~line_pend) == '0)
		else $error("pending latch not set");
	AST_HOLD: assert property (line_pend_set == '0 && line_pend_clear == '0 && line_irq == '0 && !exc_accept |=> $stable(line_pend))
		else $error("pending latch changed without cause");
	AST_RSVD: assert property (((line_pend | line_enable | line_active) & ~LINE_IMPL) == '0)
		else $error("reserved line bit set");
endmodule : exception_controller_sva
bind exception_controller exception_controller_sva exception_controller_sva_inst (.clk, .rst, .warm_reset_pin, .vec_rd_req,
	.vec_rd_addr, .vec_rd_ack, .vec_rd_data, .stack_ptr, .reset_pc, .boot_done, .line_irq, .line_enable_set,
	.line_enable_clear, .line_pend_set, .line_pend_clear, .line_enable, .line_pend, .line_active, .exc_req,
	.exc_num, .running_key, .exc_accept);
`default_nettype wire

// ---- tb/core_model.sv ----
// core-side model: vector fetch answers and exception acceptance
`timescale 1ns/1ps
`default_nettype none
module core_model #(
	parameter logic [31:0] SP_VAL = 32'h20000FF0,
	parameter logic [31:0] PC_VAL = 32'h00000101,
	parameter int SLOW = 2
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// vector fetch
	input wire logic vec_rd_req,
	input wire logic [31:0] vec_rd_addr,
	output logic vec_rd_ack,
	output logic [31:0] vec_rd_data,
	// exception handshake
	input wire logic exc_req,
	input wire logic [5:0] exc_num,
	output logic exc_accept,
	output logic taken,
	output logic [5:0] taken_num
);
	logic [3:0] wait_r;
	// data toggles outside an answer so a stale word never passes for a fetch
	always_ff @(posedge clk)
	begin
		vec_rd_ack <= !rst && vec_rd_req && !vec_rd_ack;
		vec_rd_data <= rst ? 32'h0 : (vec_rd_req && !vec_rd_ack) ? (vec_rd_addr == 32'h0 ? SP_VAL : PC_VAL) : ~vec_rd_data;
		wait_r <= (!rst && exc_req && !exc_accept) ? wait_r + 4'h1 : 4'h0;
		exc_accept <= !rst && exc_req && !exc_accept && wait_r >= SLOW;
		taken <= !rst && exc_req && exc_accept;
		if (exc_req && exc_accept)
			taken_num <= exc_num;
	end
endmodule : core_model
`default_nettype wire

// ---- tb/exception_controller_bench.sv ----
// bench for the exception controller: boot, masking, ranking, faults
`timescale 1ns/1ps
`default_nettype none
module exception_controller_bench;
	import exc_pkg::*;
	localparam logic [31:0] SP_VAL = 32'h20000FF0;
	localparam logic [31:0] PC_VAL = 32'h00000101;
	logic clk, rst, nmi_pin, warm_reset_pin, dbg_halting, dbg_mon_en, exc_return;
	logic vec_rd_req, vec_rd_ack, boot_done, thread_mode, exc_req, exc_accept, taken;
	logic [31:0] vec_rd_addr, vec_rd_data, stack_ptr, reset_pc;
	logic [9:0] ev;
	logic [2:0] fault_handler_en;
	logic [EXC_NUM-1:0][PRIO_W-1:0] exc_priority;
	logic [LINE_W-1:0] line_irq, line_enable_set, line_enable_clear, line_pend_set, line_pend_clear;
	logic [LINE_W-1:0] line_enable, line_pend, line_active;
	logic [IDX_W-1:0] exc_num, exc_return_num, taken_num;
	key_t running_key;
	int n_mismatch, checks_done;
	int exq [8] = '{4, 5, 5, 3, 11, 12, 15, 14};
	exception_controller exception_controller_inst (.clk, .rst, .nmi_pin, .warm_reset_pin, .vec_rd_req,
		.vec_rd_addr, .vec_rd_ack, .vec_rd_data, .stack_ptr, .reset_pc, .boot_done, .thread_mode,
		.first_instr_done(ev[9]), .mem_fault(ev[0]), .bus_fault_precise(ev[1]), .bus_fault_imprecise(ev[2]),
		.usage_fault(ev[3]), .svc_exec(ev[4]), .dbg_mon_req(ev[5]), .dbg_halting, .system_tick_exception_expire(ev[6]),
		.fault_handler_en, .dbg_mon_en, .pendable_service_request_set(ev[7]), .pendable_service_request_clear(ev[8]), .exc_priority, .line_irq,
		.line_enable_set, .line_enable_clear, .line_pend_set, .line_pend_clear, .line_enable, .line_pend,
		.line_active, .exc_req, .exc_num, .running_key, .exc_accept, .exc_return, .exc_return_num);
	core_model #(.SP_VAL(SP_VAL), .PC_VAL(PC_VAL), .SLOW(2)) core_model_inst (.clk, .rst, .vec_rd_req,
		.vec_rd_addr, .vec_rd_ack, .vec_rd_data, .exc_req, .exc_num, .exc_accept, .taken, .taken_num);
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// waits for the core model to take an exception, then compares its number
	task automatic take(input logic [5:0] exp);
		int i;
		for (i = 0; i < 60 && taken !== 1'h1; i++)
			@(negedge clk);
		if (taken !== 1'h1)
		begin
			n_mismatch++;
			summarize();
		end
		chk(taken_num, exp);
		@(negedge clk);
	endtask : take
	task automatic ret(input logic [5:0] n);
		exc_return_num = n;
		exc_return = 1'h1;
		@(negedge clk);
		exc_return = 1'h0;
		@(negedge clk);
	endtask : ret
	task automatic wait_boot;
		int i;
		for (i = 0; i < 20 && boot_done !== 1'h1; i++)
			@(negedge clk);
		if (boot_done !== 1'h1)
		begin
			n_mismatch++;
			summarize();
		end
	endtask : wait_boot
	task automatic lines(input logic [LINE_W-1:0] es, ec, ps, pc);
		{line_enable_set, line_enable_clear, line_pend_set, line_pend_clear} = {es, ec, ps, pc};
		@(negedge clk);
		{line_enable_set, line_enable_clear, line_pend_set, line_pend_clear} = '0;
		@(negedge clk);
	endtask : lines
	initial
	begin
		clk = 1'h0;
		forever
			#5 clk = ~clk;
	end
	initial
	begin
		int i;
		{nmi_pin, warm_reset_pin, dbg_halting, exc_return, exc_return_num, ev, line_irq} = '0;
		{line_enable_set, line_enable_clear, line_pend_set, line_pend_clear} = '0;
		exc_priority = {EXC_NUM{5'h0A}};
		fault_handler_en = 3'h3;
		dbg_mon_en = 1'h1;
		n_mismatch = 0;
		checks_done = 0;
		rst = 1'h1;
		repeat (10) @(negedge clk);
		rst = 1'h0;
		wait_boot();
		chk(stack_ptr, SP_VAL);
		chk(reset_pc, PC_VAL);
		chk({boot_done, thread_mode, running_key}, {2'h2, KEY_RESET});
		ev = 10'h200;
		@(negedge clk);
		ev = '0;
		repeat (2) @(negedge clk);
		chk({thread_mode, running_key}, {1'h1, KEY_IDLE});
		lines('0, '0, '1, '0);
		repeat (4) @(negedge clk);
		chk({exc_req, line_pend}, {1'h0, LINE_IMPL});
		lines('0, '0, '0, 17'h1AFFF);
		chk({exc_req, line_pend}, {1'h0, 17'h05000});
		lines(17'h05000, '0, '0, '0);
		take(28);
		chk(line_active, 17'h01000);
		nmi_pin = 1'h1;
		take(2);
		nmi_pin = 1'h0;
		ret(2);
		ret(28);
		take(30);
		ret(30);
		for (i = 0; i < 8; i++)
		begin
			ev = 10'h001 << i;
			@(negedge clk);
			ev = '0;
			take(exq[i][5:0]);
			ret(exq[i][5:0]);
		end
		// halting blocks the monitor; a software clear right after the set withdraws the request
		dbg_halting = 1'h1;
		ev = 10'h0A0;
		@(negedge clk);
		ev = 10'h100;
		@(negedge clk);
		ev = '0;
		repeat (6) @(negedge clk);
		chk({exc_req, running_key}, {1'h0, KEY_IDLE});
		dbg_halting = 1'h0;
		exc_priority[POS_MGMT] = 5'h01;
		exc_priority[POS_TICK] = 5'h1F;
		lines(17'h4, '0, '0, '0);
		ev = 10'h040;
		lines('0, '0, 17'h4, '0);
		ev = '0;
		take(18);
		ev = 10'h001;
		@(negedge clk);
		ev = '0;
		take(3);
		ret(3);
		ret(18);
		take(15);
		ret(15);
		lines(17'h8, '0, '0, '0);
		line_irq = 17'h8;
		take(19);
		ret(19);
		take(19);
		lines('0, '0, '0, 17'h8);
		chk(line_pend[3], 1'h1);
		line_irq = '0;
		lines('0, 17'h8, '0, 17'h8);
		ret(19);
		repeat (3) @(negedge clk);
		chk({exc_req, line_pend[3], line_enable[3]}, 3'h0);
		// warm reset in mid-run: state back to its reset value, then a fresh vector fetch
		warm_reset_pin = 1'h1;
		repeat (4) @(negedge clk);
		chk({boot_done, vec_rd_req, line_enable, running_key}, {2'h1, 17'h0, KEY_RESET});
		warm_reset_pin = 1'h0;
		wait_boot();
		chk({boot_done, thread_mode}, 2'h2);
		chk(stack_ptr, SP_VAL);
		chk(reset_pc, PC_VAL);
		summarize();
	end
endmodule : exception_controller_bench
`default_nettype wire
